// ==== verilog/adcctl_top.sv ====
// Purpose: control and sequencing around one successive-approx converter
// Assumes: 125 MHz clock, sub clock arrives asynchronously on a pin
// Notes:   analog core supplies the 12-bit result on core_result_in
//
// Function
// RULE1 - enable bit switches bandgap for converter
// RULE2 - bandgap off when no user needs it
// RULE3 - alignment bit picks left or right result
// RULE4 - two-bit field selects converter reference
// RULE5 - external reference code claims shared pin
// RULE6 - divider code picks sysclk division or subclk
// RULE7 - start low-high-low begins one conversion
// RULE8 - start held high resets, busy forced
// RULE9 - busy clears on finish, read only
// RULE10 - finish sets request flag, interrupt if enabled
// RULE11 - software polls busy before reading result
// RULE12 - software keeps clock period in range
// RULE13 - software waits settling after power on
// RULE14 - software waits reference settling time
// RULE15 - analog pin drops other functions, pullups
// RULE16 - analog selection overrides port direction
// RULE17 - software clears start before sequence
// RULE18 - software sets both interrupt enables
// RULE19 - config bit seven reads zero, others reset
// RULE20 - software powers converter off when unused
// RULE21 - conversion lasts sixteen conversion clocks
// RULE22 - power-off bit powers converter down
// RULE23 - channel top bit routes bandgap to input
// RULE24 - unused result bits read as zero
// RULE25 - result loads with busy clear
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module adcctl_top
  import adcctl_pkg::*;
#(
  parameter int PINS = 16
) (
  input  wire logic            clock_in,
  input  wire logic            reset_in,
  input  wire logic [2:0]      addr_in,
  input  wire logic [7:0]      wdata_in,
  input  wire logic            wr_in,
  input  wire logic            rd_in,
  output logic      [7:0]      rdata_out,
  input  wire logic            sub_clock_in,
  input  wire logic [11:0]     core_result_in,
  input  wire logic            low_voltage_monitors_in,
  input  wire logic [PINS-1:0] port_direction_control_in,
  input  wire logic [PINS-1:0] pullup_enable_in,
  output logic                 core_reset_out,
  output logic                 core_clock_en_out,
  output logic                 core_sample_out,
  output logic                 core_power_out,
  output logic                 bandgap_on_out,
  output logic [1:0]           ref_source_out,
  output logic                 ref_pin_claim_out,
  output logic                 bandgap_to_input_out,
  output logic [3:0]           channel_out,
  output logic [PINS-1:0]      pin_analog_out,
  output logic [PINS-1:0]      pin_input_only_out,
  output logic [PINS-1:0]      pin_pullup_out,
  output logic                 irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]      ctrl0_reg;
  logic [6:0]      cfg1_reg;
  logic [11:0]     result_reg;
  logic [PINS-1:0] pfs_reg;
  logic [2:0]      int_reg;
  logic [DIV_W-1:0] div_reg;
  logic [4:0]      cnt_reg;
  logic            sub_s1_reg;
  logic            sub_s2_reg;
  logic            sub_s3_reg;
  adcctl_state_t   state_reg;
  adcctl_state_t   state_next;

  wire start_bit  = ctrl0_reg[CTRL0_START];
  wire power_off  = ctrl0_reg[CTRL0_POFF];
  wire align_bit  = cfg1_reg[CFG1_ALIGN];
  wire [1:0] ref_sel  = cfg1_reg[CFG1_REFSH:CFG1_REFSL];
  wire [2:0] div_sel  = cfg1_reg[CFG1_DIVH:0];
  wire wr_ctrl0   = wr_in && addr_in == ADR_CTRL0;
  wire wr_cfg1    = wr_in && addr_in == ADR_CFG1;
  wire wr_int     = wr_in && addr_in == ADR_INTCTL;
  wire new_start  = wdata_in[CTRL0_START];

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock enable
  // RULE6 divider tap
  // a divide-by-2^k enable fires when the low k counter bits are all ones
  wire [DIV_W-1:0] div_mask = DIV_W'((7'h01 << div_sel) - 7'h01);
  wire div_tick   = (div_reg & div_mask) == div_mask;
  // sub clock edge is read only after the second synchroniser stage
  wire sub_tick   = sub_s2_reg && !sub_s3_reg;
  wire conv_tick  = (div_sel == DIV_SUBCLK) ? sub_tick : div_tick;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      div_reg    <= '0;
      sub_s1_reg <= 1'b0;
      sub_s2_reg <= 1'b0;
      sub_s3_reg <= 1'b0;
    end else begin
      div_reg    <= div_reg + DIV_W'(1);
      sub_s1_reg <= sub_clock_in;
      sub_s2_reg <= sub_s1_reg;
      sub_s3_reg <= sub_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start sequencing
  wire conv_last = conv_tick && cnt_reg == CONV_CLKS - 5'h01;
  // RULE7 falling start edge
  wire start_fall = wr_ctrl0 && start_bit && !new_start;
  // RULE8 rising start edge
  wire start_rise = wr_ctrl0 && !start_bit && new_start;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ADCCTL_IDLE_S:  if (start_rise) state_next = ADCCTL_RESET_S;
      ADCCTL_RESET_S: if (start_fall) state_next = ADCCTL_CONV_S;
      ADCCTL_CONV_S: begin
        if (start_rise) state_next = ADCCTL_RESET_S;
        else if (conv_last) state_next = ADCCTL_IDLE_S;
      end
      default:        state_next = ADCCTL_IDLE_S;
    endcase
  end

  // RULE21 sixteen-clock count
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg <= ADCCTL_IDLE_S;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg != ADCCTL_CONV_S) cnt_reg <= '0;
      else if (conv_tick) cnt_reg <= cnt_reg + 5'h01;
    end
  end

  wire conv_done = state_reg == ADCCTL_CONV_S && conv_last && !start_rise;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  // RULE9 busy set and clear
  wire busy_next = start_rise ? 1'b1 : (conv_done ? 1'b0 :
                   ctrl0_reg[CTRL0_BUSY]);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl0_reg <= CTRL0_RST;
      cfg1_reg  <= CFG1_RST;
      pfs_reg   <= '0;
    end else begin
      ctrl0_reg[CTRL0_BUSY] <= busy_next;
      if (wr_ctrl0) begin
        ctrl0_reg[CTRL0_START] <= new_start;
        ctrl0_reg[CTRL0_POFF:0] <= wdata_in[CTRL0_POFF:0];
      end
      // RULE19 bit seven dropped
      if (wr_cfg1) cfg1_reg <= wdata_in[6:0];
      if (wr_in && addr_in == ADR_PFS_LO) pfs_reg[7:0] <= wdata_in;
      if (wr_in && addr_in == ADR_PFS_HI) pfs_reg[PINS-1:8] <= wdata_in;
    end
  end

  // RULE25 result with busy clear
  always_ff @(posedge clock_in) begin
    if (reset_in) result_reg <= '0;
    else if (conv_done) result_reg <= core_result_in;
  end

  // RULE10 request flag set wins
  wire flag_clr  = wr_int && !wdata_in[INT_FLAG];
  wire flag_next = conv_done || (int_reg[INT_FLAG] && !flag_clr);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      int_reg <= '0;
      irq_out <= 1'b0;
    end else begin
      if (wr_int) int_reg[INT_CIE:INT_GIE] <= wdata_in[INT_CIE:INT_GIE];
      int_reg[INT_FLAG] <= flag_next;
      // RULE10 interrupt gated by enables
      irq_out <= flag_next && int_reg[INT_GIE] && int_reg[INT_CIE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  // RULE3 alignment
  // RULE24 unused bits zero
  wire [7:0] res_lo = align_bit ? result_reg[7:0] : {result_reg[3:0], 4'h0};
  wire [7:0] res_hi = align_bit ? {4'h0, result_reg[11:8]} :
                      result_reg[11:4];
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr_in)
      ADR_CTRL0:  rd_mux = ctrl0_reg;
      // RULE19 bit seven reads zero
      ADR_CFG1:   rd_mux = {1'b0, cfg1_reg};
      ADR_RES_LO: rd_mux = res_lo;
      ADR_RES_HI: rd_mux = res_hi;
      ADR_PFS_LO: rd_mux = pfs_reg[7:0];
      ADR_PFS_HI: rd_mux = pfs_reg[PINS-1:8];
      ADR_INTCTL: rd_mux = {5'h00, int_reg};
      default:    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) rdata_out <= 8'h00;
    else rdata_out <= rd_in ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog side controls
  // RULE1 converter use of bandgap
  wire ref_used = cfg1_reg[CFG1_REFEN] || ref_sel[1];
  // RULE2 auto power down
  wire bg_on    = ref_used || low_voltage_monitors_in;
  // RULE15 analog pins lose pullups
  // RULE16 direction overridden
  wire [PINS-1:0] pull_next = pullup_enable_in & ~pfs_reg;
  wire [PINS-1:0] inonly    = pfs_reg | port_direction_control_in;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      core_reset_out       <= 1'b0;
      core_clock_en_out    <= 1'b0;
      core_sample_out      <= 1'b0;
      core_power_out       <= 1'b0;
      bandgap_on_out       <= 1'b0;
      ref_source_out       <= REF_SUPPLY;
      ref_pin_claim_out    <= 1'b0;
      bandgap_to_input_out <= 1'b0;
      channel_out          <= '0;
      pin_analog_out       <= '0;
      pin_input_only_out   <= '0;
      pin_pullup_out       <= '0;
    end else begin
      // RULE8 converter held in reset
      core_reset_out       <= state_reg == ADCCTL_RESET_S;
      core_clock_en_out    <= state_reg == ADCCTL_CONV_S && conv_tick;
      core_sample_out      <= conv_done;
      // RULE22 power control
      core_power_out       <= !power_off;
      bandgap_on_out       <= bg_on;
      // RULE4 reference choice
      ref_source_out       <= ref_sel;
      // RULE5 shared pin claim
      ref_pin_claim_out    <= ref_sel == REF_EXTPIN;
      // RULE23 bandgap to input
      bandgap_to_input_out <= ctrl0_reg[CTRL0_CHTOP];
      channel_out          <= ctrl0_reg[3:0];
      pin_analog_out       <= pfs_reg;
      pin_input_only_out   <= inonly;
      pin_pullup_out       <= pull_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_busy_on_rise;
    @(posedge clock_in) disable iff (reset_in)
    start_rise |=> ctrl0_reg[CTRL0_BUSY] ##1 core_reset_out;
  endproperty
  a_busy_on_rise: assert property (p_busy_on_rise) // RULE8
    else $error("busy or core reset missing after start rise");

  property p_fall_converts;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == ADCCTL_RESET_S && start_fall) |=>
      state_reg == ADCCTL_CONV_S;
  endproperty
  a_fall_converts: assert property (p_fall_converts) // RULE7
    else $error("falling start did not begin conversion");

  property p_done_clears;
    @(posedge clock_in) disable iff (reset_in)
    conv_done |=> !ctrl0_reg[CTRL0_BUSY] && result_reg == $past(core_result_in)
      && int_reg[INT_FLAG];
  endproperty
  a_done_clears: assert property (p_done_clears) // RULE9
    else $error("done did not clear busy, load result, set flag");

  property p_sixteen;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == ADCCTL_CONV_S && cnt_reg == 5'h00 && div_sel == 3'h0)
      |-> ##15 conv_done;
  endproperty
  a_sixteen: assert property (p_sixteen) // RULE21
    else $error("conversion ended at wrong count");

  property p_bit7_zero;
    @(posedge clock_in) disable iff (reset_in)
    (rd_in && addr_in == ADR_CFG1) |=> !rdata_out[7];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) // RULE19
    else $error("config bit seven read nonzero");

  property p_align;
    @(posedge clock_in) disable iff (reset_in)
    (rd_in && addr_in == ADR_RES_HI && align_bit) |=> rdata_out[7:4] == 4'h0;
  endproperty
  a_align: assert property (p_align) // RULE24
    else $error("right aligned high byte has nonzero top bits");

  property p_extpin;
    @(posedge clock_in) disable iff (reset_in)
    (ref_sel == REF_EXTPIN) |=> ref_pin_claim_out;
  endproperty
  a_extpin: assert property (p_extpin) // RULE5
    else $error("external reference pin not claimed");

  property p_pullup;
    @(posedge clock_in) disable iff (reset_in)
    ##1 (pin_pullup_out & pin_analog_out) == '0;
  endproperty
  a_pullup: assert property (p_pullup) // RULE15
    else $error("pullup left on analog pin");
endmodule

// ==== common/adcctl_pkg.sv ====
// Purpose: constants for the converter control block
// Assumes: 8-bit registers on a plain strobe port
// Notes:   register indices are word offsets of this block
package adcctl_pkg;
  // register indices
  localparam logic [2:0] ADR_CTRL0  = 3'h0;
  localparam logic [2:0] ADR_CFG1   = 3'h1;
  localparam logic [2:0] ADR_RES_LO = 3'h2;
  localparam logic [2:0] ADR_RES_HI = 3'h3;
  localparam logic [2:0] ADR_PFS_LO = 3'h4;
  localparam logic [2:0] ADR_PFS_HI = 3'h5;
  localparam logic [2:0] ADR_INTCTL = 3'h6;
  // first control register fields
  localparam int CTRL0_START = 7;
  localparam int CTRL0_BUSY  = 6;
  localparam int CTRL0_POFF  = 5;
  localparam int CTRL0_CHTOP = 4;
  // second configuration register fields
  localparam int CFG1_REFEN  = 6;
  localparam int CFG1_ALIGN  = 5;
  localparam int CFG1_REFSH  = 4;
  localparam int CFG1_REFSL  = 3;
  localparam int CFG1_DIVH   = 2;
  // interrupt control fields
  localparam int INT_GIE     = 0;
  localparam int INT_CIE     = 1;
  localparam int INT_FLAG    = 2;
  // reset values
  localparam logic [7:0] CTRL0_RST  = 8'h60;
  localparam logic [6:0] CFG1_RST   = 7'h00;
  // reference select codes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXTPIN = 2'h1;
  // conversion clock
  localparam logic [2:0] DIV_SUBCLK = 3'h7;
  localparam logic [4:0] CONV_CLKS  = 5'h10;
  localparam int         DIV_W      = 6;
  typedef enum logic [1:0] {
    ADCCTL_IDLE_S  = 2'b00,
    ADCCTL_RESET_S = 2'b01,
    ADCCTL_CONV_S  = 2'b11
  } adcctl_state_t;
endpackage

// ==== bench/adcctl_analog_model.sv ====
// Purpose: analog core and sub clock stand-in for the control block
// Assumes: result is taken by the block before core_sample_in pulses
// Notes:   result is scrambled once sampled, so a late capture shows
`timescale 1ns/1ps
module adcctl_analog_model (
  input  wire logic        clock_in,
  input  wire logic        core_reset_in,
  input  wire logic        core_sample_in,
  output logic             sub_clock_out,
  output logic      [11:0] core_result_out,
  output logic      [11:0] expect_out
);
  logic rst_q = 1'b0;
  logic live_q = 1'b1;

  initial begin
    sub_clock_out = 1'b0;
    expect_out = 12'hA5C;
  end

  // free-running slow clock, unrelated in phase to clock_in
  // period 512 ns, inside the legal conversion clock range
  always #256 sub_clock_out = ~sub_clock_out;

  ////////////////////////////////////////
  // new value per conversion; inverted once sampled
  always @(posedge clock_in) begin
    rst_q <= core_reset_in;
    if (core_reset_in && !rst_q) begin
      expect_out <= {expect_out[10:0],
                     expect_out[11] ^ expect_out[5] ^ expect_out[0]};
    end
    if (core_reset_in) begin
      live_q <= 1'b1;
    end else if (core_sample_in) begin
      live_q <= 1'b0;
    end
  end

  assign core_result_out = live_q ? expect_out : ~expect_out;
endmodule

// ==== bench/adcctl_top_tb.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: registers are reached over the plain strobe port
// Notes:   conversion timing is checked with a one-tick margin
`timescale 1ns/1ps
module adcctl_top_tb;
  import adcctl_pkg::*;
  logic        clock_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [2:0]  addr_in = 3'h0;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [7:0]  rdata_out;
  logic        sub_clock_in;
  logic [11:0] core_result_in;
  logic [11:0] model_val;
  logic        lvm = 1'b0;
  logic [15:0] dir = 16'h0000;
  logic [15:0] pu = 16'h0000;
  logic        core_reset_out;
  logic        core_sample_out;
  logic        core_power_out;
  logic        bandgap_on_out;
  logic [1:0]  ref_source_out;
  logic        ref_pin_claim_out;
  logic        bg_in_out;
  logic [3:0]  channel_out;
  logic [15:0] an_out;
  logic [15:0] in_only_out;
  logic [15:0] pullup_out;
  logic        irq_out;
  logic        core_clock_en_out;
  int          n_ticks = 0;
  int          n_samples = 0;
  // settle wait after power-up or reference enable, value arbitrary
  localparam int SETTLE_CYC = 64;
  integer      seed = 32'h779c;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [31:0] v;
  logic [15:0] an;
  logic [7:0]  lo;
  logic [7:0]  hi;

  always #4 clock_in = ~clock_in;

  adcctl_top i_adcctl_top (
    .clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sub_clock_in(sub_clock_in),
    .core_result_in(core_result_in), .low_voltage_monitors_in(lvm),
    .port_direction_control_in(dir), .pullup_enable_in(pu),
    .core_reset_out(core_reset_out),
    .core_clock_en_out(core_clock_en_out),
    .core_sample_out(core_sample_out), .core_power_out(core_power_out),
    .bandgap_on_out(bandgap_on_out), .ref_source_out(ref_source_out),
    .ref_pin_claim_out(ref_pin_claim_out),
    .bandgap_to_input_out(bg_in_out), .channel_out(channel_out),
    .pin_analog_out(an_out), .pin_input_only_out(in_only_out),
    .pin_pullup_out(pullup_out), .irq_out(irq_out));

  adcctl_analog_model i_adcctl_analog_model (
    .clock_in(clock_in), .core_reset_in(core_reset_out),
    .core_sample_in(core_sample_out), .sub_clock_out(sub_clock_in),
    .core_result_out(core_result_in), .expect_out(model_val));

  // conversion clock and sample pulses, counted per conversion
  always @(posedge clock_in) begin
    if (core_reset_out) begin
      n_ticks <= 0;
      n_samples <= 0;
    end else begin
      if (core_clock_en_out) n_ticks <= n_ticks + 1;
      if (core_sample_out) n_samples <= n_samples + 1;
    end
  end

  ////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] e,
                      input string what);
    logic [7:0] d;
    rd(a, d);
    chk(16'(d), 16'(e), what);
  endtask

  // left alignment pads low nibble, right alignment pads high nibble
  function automatic logic [15:0] aligned(input logic [11:0] r,
                                          input logic al);
    return al ? {4'h0, r} : {r, 4'h0};
  endfunction

  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clock_in);
    reset_in <= 1'b0;
    rchk(ADR_CTRL0, CTRL0_RST, "ctrl0 reset");
    rchk(ADR_CFG1, 8'h00, "cfg1 reset");
    wr(ADR_CFG1, 8'hFF);
    rchk(ADR_CFG1, 8'h7F, "cfg1 top bit");
    rchk(3'h7, 8'h00, "unmapped read");
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      lvm <= v[7];
      wr(ADR_CFG1, {1'b0, v[6], 1'b0, 2'(i), 3'h0});
      repeat (2) @(posedge clock_in);
      chk(16'(ref_source_out), 16'(i % 4), "ref source");
      chk(16'(ref_pin_claim_out), 16'(i % 4 == 1), "ref pin");
      chk(16'(bandgap_on_out), 16'(v[6] | i[1] | v[7]), "bg");
    end
    wr(ADR_CTRL0, 8'h1A);
    repeat (2) @(posedge clock_in);
    chk(16'(core_power_out), 16'h1, "power on");
    chk({11'h0, bg_in_out, channel_out}, 16'h1A, "chan top");
    wr(ADR_CTRL0, 8'h25);
    repeat (2) @(posedge clock_in);
    chk(16'(core_power_out), 16'h0, "power off");
    chk({11'h0, bg_in_out, channel_out}, 16'h05, "chan");
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      an = (i == 0) ? 16'hFFFF : v[15:0];
      dir <= v[31:16];
      pu <= v[23:8];
      wr(ADR_PFS_LO, an[7:0]);
      wr(ADR_PFS_HI, an[15:8]);
      repeat (2) @(posedge clock_in);
      chk(an_out, an, "analog pins");
      chk(in_only_out, an | v[31:16], "dir override");
      chk(pullup_out, v[23:8] & ~an, "pullups");
    end
    wr(ADR_CTRL0, 8'h00);
    repeat (SETTLE_CYC) @(posedge clock_in);
    // codes below 6 are too fast at 125 MHz; codes below 7 use fixed waits and a busy-during check, code 7 polls busy instead
    for (int c = 0; c < 8; c++) begin
      wr(ADR_INTCTL, {6'h0, 1'b1, c[1]});
      wr(ADR_CFG1, {2'b00, c[0], 2'b00, 3'(c)});
      wr(ADR_CTRL0, 8'h80);
      repeat (2) @(posedge clock_in);
      chk(16'(core_reset_out), 16'h1, "core reset");
      rchk(ADR_CTRL0, 8'hC0, "busy forced");
      wr(ADR_CTRL0, 8'h00);
      if (c < 7) begin
        repeat ((15 << c) - 8) @(posedge clock_in);
        rchk(ADR_CTRL0, 8'h40, "busy during");
        repeat ((1 << c) + 12) @(posedge clock_in);
      end else begin
        lo = 8'h40;
        for (int k = 0; k < 1000 && lo[6]; k++) begin
          rd(ADR_CTRL0, lo);
        end
      end
      rchk(ADR_CTRL0, 8'h00, "busy cleared");
      rd(ADR_RES_LO, lo);
      rd(ADR_RES_HI, hi);
      chk({hi, lo}, aligned(model_val, c[0]), "result");
      chk(16'(n_ticks), 16'(CONV_CLKS), "tick count");
      chk(16'(n_samples), 16'h1, "sample pulse");
      chk(16'(irq_out), 16'(c[1]), "irq");
      rchk(ADR_INTCTL, {5'h0, 2'b11, c[1]}, "flag set");
      wr(ADR_INTCTL, 8'h00);
      repeat (2) @(posedge clock_in);
      chk(16'(irq_out), 16'h0, "irq cleared");
    end
    wr(ADR_CTRL0, 8'h20);
    repeat (2) @(posedge clock_in);
    chk(16'(core_power_out), 16'h0, "idle power down");
    print_verdict();
  end
endmodule
